// File: design/cps_regs.sv
`timescale 1ns/1ps
module cps_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register access from the serial management front end
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // External control pins
    input wire logic port_power_request,
    input wire logic mode_input_a,
    input wire logic mode_input_b,
    input wire logic emulation_allow,
    input wire logic polarity_strap,
    // Emulation engine and port events
    input wire logic [2:0] legacy_profile_accept,
    input wire logic removal_detected,
    input wire logic attach_detected,
    input wire logic fault_detected,
    input wire logic fault_cleared,
    input wire logic sleep_request,
    // Switch steering
    input wire logic data_switch_default,
    input wire logic [1:0] default_limit_behaviour,
    input wire logic [1:0] custom_limit_behaviour,
    output logic data_switch_closed,
    output logic [1:0] current_limit_behaviour,
    // Effective control states for the rest of the device
    output logic port_power_request_state,
    output logic [1:0] power_state_code,
    output logic [7:0] general_config
);

    logic [4:0] pins_sync;
    logic [2:0] legacy_status_reg;
    logic [7:0] emulation_config_reg;
    logic [7:0] switch_config_reg;
    logic [7:0] attach_detect_config_reg;
    logic [7:0] data_switch_config_reg;
    logic polarity_high_reg;
    logic strap_taken_reg;
    logic [1:0] strap_count_reg;
    logic first_cycle_reg;
    logic [1:0] mode_prev_reg;
    logic mode_input_a_state;
    logic mode_input_b_state;
    logic emulation_allow_state;
    logic mode_changed;
    logic profile_clear;
    logic bus_access;
    logic [7:0] status_byte;
    cps_pkg::cps_power_state_type power_state_reg;
    cps_pkg::cps_power_state_type power_state_next;

    // Code of a one-hot power state
    function automatic logic [1:0] state_code(input cps_pkg::cps_power_state_type st);
        case (st)
            cps_pkg::PST_SLEEP: state_code = cps_pkg::PSTATE_CODE_SLEEP;
            cps_pkg::PST_DETECT: state_code = cps_pkg::PSTATE_CODE_DETECT;
            cps_pkg::PST_ACTIVE: state_code = cps_pkg::PSTATE_CODE_ACTIVE;
            cps_pkg::PST_ERROR: state_code = cps_pkg::PSTATE_CODE_ERROR;
            default: state_code = cps_pkg::PSTATE_CODE_ERROR;
        endcase
    endfunction : state_code

    cps_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in({polarity_strap, emulation_allow, mode_input_a, mode_input_b, port_power_request}),
        .sync_out(pins_sync)
    );

    // Strap capture waits for the synchroniser to fill
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_count_reg <= 2'h0;
            strap_taken_reg <= 1'b0;
            polarity_high_reg <= 1'b0;
        end
        else if (!strap_taken_reg)
        begin
            strap_count_reg <= strap_count_reg + 2'h1;
            if (strap_count_reg == cps_pkg::STRAP_CAPTURE_COUNT)
            begin
                polarity_high_reg <= pins_sync[4];
                strap_taken_reg <= 1'b1;
            end
        end
    end

    // effective power request, polarity then soft override
    assign port_power_request_state = (polarity_high_reg ? pins_sync[0] : ~pins_sync[0])
        | switch_config_reg[cps_pkg::SWCFG_POWER_REQUEST_SOFT_BIT];

    assign mode_input_b_state = pins_sync[1] | switch_config_reg[cps_pkg::SWCFG_MODE_B_OVERRIDE_BIT];
    assign mode_input_a_state = pins_sync[2] | switch_config_reg[cps_pkg::SWCFG_MODE_A_OVERRIDE_BIT];
    assign emulation_allow_state = pins_sync[3] | switch_config_reg[cps_pkg::SWCFG_EMULATION_ALLOW_OVERRIDE_BIT];

    // Mode history for new active mode detection
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_prev_reg <= 2'h0;
            first_cycle_reg <= 1'b1;
        end
        else
        begin
            mode_prev_reg <= {mode_input_b_state, mode_input_a_state};
            first_cycle_reg <= 1'b0;
        end
    end

    assign mode_changed = ({mode_input_b_state, mode_input_a_state} != mode_prev_reg);
    assign profile_clear = !port_power_request_state || mode_changed || removal_detected;

    // Legacy profile bits; a handshake in the clear cycle is kept
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            legacy_status_reg <= 3'h0;
        // set by accepted handshake, set wins
        else if (profile_clear)
            legacy_status_reg <= legacy_profile_accept;
        else
            legacy_status_reg <= legacy_status_reg | legacy_profile_accept;
    end

    profile_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        |legacy_profile_accept |=> ((legacy_status_reg & $past(legacy_profile_accept)) == $past(legacy_profile_accept)))
        else $error("accepted legacy profile not recorded");

    // clear without a handshake empties the field
    profile_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (profile_clear && legacy_profile_accept == 3'h0) |=> legacy_status_reg == 3'h0)
        else $error("legacy profile bits not cleared");

    // Switch steering registered to avoid glitches on the switch drivers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_switch_closed <= 1'b0;
            current_limit_behaviour <= 2'h0;
        end
        else if (|legacy_status_reg)
        begin
            data_switch_closed <= data_switch_config_reg[cps_pkg::DSWCFG_DEDICATED_CHARGE_CTL_BIT];
            current_limit_behaviour <= custom_limit_behaviour;
        end
        else
        begin
            data_switch_closed <= data_switch_default;
            current_limit_behaviour <= default_limit_behaviour;
        end
    end

    // switch follows config while profile accepted
    data_switch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        |legacy_status_reg |=> data_switch_closed == $past(data_switch_config_reg[cps_pkg::DSWCFG_DEDICATED_CHARGE_CTL_BIT]))
        else $error("data switch ignores dedicated charge control");

    limit_select_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        |legacy_status_reg |=> current_limit_behaviour == $past(custom_limit_behaviour))
        else $error("limit behaviour not custom during legacy profile");

    assign bus_access = reg_read || reg_write;

    // Power state machine
    always_comb
    begin
        power_state_next = power_state_reg;
        case (power_state_reg)
            cps_pkg::PST_SLEEP:
                if (fault_detected)
                    power_state_next = cps_pkg::PST_ERROR;
                else if (bus_access || attach_detected)
                    power_state_next = cps_pkg::PST_DETECT;
            cps_pkg::PST_DETECT:
                if (fault_detected)
                    power_state_next = cps_pkg::PST_ERROR;
                else if (attach_detected && port_power_request_state)
                    power_state_next = cps_pkg::PST_ACTIVE;
                else if (sleep_request && !bus_access)
                    power_state_next = cps_pkg::PST_SLEEP;
            cps_pkg::PST_ACTIVE:
                if (fault_detected)
                    power_state_next = cps_pkg::PST_ERROR;
                else if (removal_detected || !port_power_request_state)
                    power_state_next = cps_pkg::PST_DETECT;
            cps_pkg::PST_ERROR:
                if (fault_cleared)
                    power_state_next = cps_pkg::PST_DETECT;
            default:
                power_state_next = cps_pkg::PST_DETECT;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            power_state_reg <= cps_pkg::PST_DETECT;
        else
            power_state_reg <= power_state_next;
    end

    assign power_state_code = state_code(power_state_reg);

    // woken state leaves sleep within one cycle
    wake_on_access_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_access && !fault_detected && power_state_reg == cps_pkg::PST_SLEEP)
        |=> power_state_code == cps_pkg::PSTATE_CODE_DETECT)
        else $error("bus access did not wake from sleep");

    // status byte; an access during sleep reports the woken code
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[cps_pkg::STAT_TOP_BIT] = 1'b0;
        status_byte[cps_pkg::STAT_POWER_REQUEST_BIT] = port_power_request_state;
        status_byte[cps_pkg::STAT_MODE_B_BIT] = mode_input_b_state;
        status_byte[cps_pkg::STAT_MODE_A_BIT] = mode_input_a_state;
        status_byte[cps_pkg::STAT_EMULATION_ALLOW_BIT] = emulation_allow_state;
        status_byte[cps_pkg::STAT_POLARITY_BIT] = polarity_high_reg;
        status_byte[1:0] = state_code(power_state_next);
    end

    // only reset_n clears them, sleep leaves them alone
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            general_config <= cps_pkg::RST_GENERAL_CONFIG;
            emulation_config_reg <= cps_pkg::RST_EMULATION_CONFIG;
            switch_config_reg <= cps_pkg::RST_SWITCH_CONFIG;
            attach_detect_config_reg <= cps_pkg::RST_ATTACH_DETECT_CONFIG;
            data_switch_config_reg <= cps_pkg::RST_DATA_SWITCH_CONFIG;
        end
        else if (reg_write)
        begin
            // status offsets fall through, no effect
            case (reg_addr)
                cps_pkg::ADDR_GENERAL_CONFIG: general_config <= reg_wdata;
                cps_pkg::ADDR_EMULATION_CONFIG: emulation_config_reg <= reg_wdata;
                cps_pkg::ADDR_SWITCH_CONFIG: switch_config_reg <= reg_wdata;
                cps_pkg::ADDR_ATTACH_DETECT_CONFIG: attach_detect_config_reg <= reg_wdata;
                cps_pkg::ADDR_DATA_SWITCH_CONFIG: data_switch_config_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // defaults seen at first edge after release
    config_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        first_cycle_reg |-> (general_config == cps_pkg::RST_GENERAL_CONFIG
        && emulation_config_reg == cps_pkg::RST_EMULATION_CONFIG && switch_config_reg == cps_pkg::RST_SWITCH_CONFIG
        && attach_detect_config_reg == cps_pkg::RST_ATTACH_DETECT_CONFIG
        && data_switch_config_reg == cps_pkg::RST_DATA_SWITCH_CONFIG))
        else $error("configuration defaults wrong after reset");

    // general config moves only on its own write
    general_retain_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(reg_write && reg_addr == cps_pkg::ADDR_GENERAL_CONFIG) |=> $stable(general_config))
        else $error("general configuration changed without a write");

    // Read data registered, one cycle after the read strobe
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_read;
            if (reg_read)
            begin
                case (reg_addr)
                    cps_pkg::ADDR_LEGACY_PROFILE_STATUS: reg_rdata <= {5'h00, legacy_status_reg};
                    cps_pkg::ADDR_CONTROL_INPUT_STATUS: reg_rdata <= status_byte;
                    cps_pkg::ADDR_GENERAL_CONFIG: reg_rdata <= general_config;
                    cps_pkg::ADDR_EMULATION_CONFIG: reg_rdata <= emulation_config_reg;
                    cps_pkg::ADDR_SWITCH_CONFIG: reg_rdata <= switch_config_reg;
                    cps_pkg::ADDR_ATTACH_DETECT_CONFIG: reg_rdata <= attach_detect_config_reg;
                    cps_pkg::ADDR_DATA_SWITCH_CONFIG: reg_rdata <= data_switch_config_reg;
                    default: reg_rdata <= cps_pkg::RST_UNMAPPED_READ;
                endcase
            end
        end
    end

    // bit 6 read back equals effective request
    power_bit_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_read && reg_addr == cps_pkg::ADDR_CONTROL_INPUT_STATUS)
        |=> reg_rvalid && reg_rdata[cps_pkg::STAT_POWER_REQUEST_BIT] == $past(port_power_request_state))
        else $error("power request status bit wrong");

    // status read never returns the sleep code
    no_sleep_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_read && reg_addr == cps_pkg::ADDR_CONTROL_INPUT_STATUS && !fault_detected)
        |=> reg_rdata[1:0] != 2'b00)
        else $error("sleep code read over the bus");

    // top bit of status reads zero
    status_top_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_read && (reg_addr == cps_pkg::ADDR_LEGACY_PROFILE_STATUS
        || reg_addr == cps_pkg::ADDR_CONTROL_INPUT_STATUS)) |=> !reg_rdata[7])
        else $error("status top bit not zero");

    strap_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        strap_taken_reg |=> $stable(polarity_high_reg) && strap_taken_reg)
        else $error("polarity strap changed after capture");

endmodule : cps_regs

// File: design/cps_pkg.sv
package cps_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_LEGACY_PROFILE_STATUS = 8'h13;
    localparam logic [7:0] ADDR_CONTROL_INPUT_STATUS = 8'h14;
    localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'h15;
    localparam logic [7:0] ADDR_EMULATION_CONFIG = 8'h16;
    localparam logic [7:0] ADDR_SWITCH_CONFIG = 8'h17;
    localparam logic [7:0] ADDR_ATTACH_DETECT_CONFIG = 8'h18;
    localparam logic [7:0] ADDR_DATA_SWITCH_CONFIG = 8'h25;

    // Reset values
    localparam logic [7:0] RST_GENERAL_CONFIG = 8'h01;
    localparam logic [7:0] RST_EMULATION_CONFIG = 8'h8c;
    localparam logic [7:0] RST_SWITCH_CONFIG = 8'h04;
    localparam logic [7:0] RST_ATTACH_DETECT_CONFIG = 8'h46;
    localparam logic [7:0] RST_DATA_SWITCH_CONFIG = 8'h14;
    localparam logic [7:0] RST_UNMAPPED_READ = 8'h00;

    // Legacy profile status field
    localparam int LEGACY_PROFILE_COUNT = 3;
    localparam int LEGACY_PROFILE_LSB = 0;

    // Control input status field positions
    localparam int STAT_TOP_BIT = 7;
    localparam int STAT_POWER_REQUEST_BIT = 6;
    localparam int STAT_MODE_B_BIT = 5;
    localparam int STAT_MODE_A_BIT = 4;
    localparam int STAT_EMULATION_ALLOW_BIT = 3;
    localparam int STAT_POLARITY_BIT = 2;

    // Override bits in switch_config
    localparam int SWCFG_POWER_REQUEST_SOFT_BIT = 7;
    localparam int SWCFG_MODE_B_OVERRIDE_BIT = 6;
    localparam int SWCFG_MODE_A_OVERRIDE_BIT = 5;
    localparam int SWCFG_EMULATION_ALLOW_OVERRIDE_BIT = 4;

    // Dedicated charge data switch control bit in data_switch_config
    localparam int DSWCFG_DEDICATED_CHARGE_CTL_BIT = 0;

    // Power state codes
    localparam logic [1:0] PSTATE_CODE_SLEEP = 2'h0;
    localparam logic [1:0] PSTATE_CODE_DETECT = 2'h1;
    localparam logic [1:0] PSTATE_CODE_ACTIVE = 2'h2;
    localparam logic [1:0] PSTATE_CODE_ERROR = 2'h3;

    // Synchroniser depth and strap capture delay
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] STRAP_CAPTURE_COUNT = 2'h2;

    // Power states, one-hot
    typedef enum logic [3:0] {
        PST_SLEEP = 4'h1,
        PST_DETECT = 4'h2,
        PST_ACTIVE = 4'h4,
        PST_ERROR = 4'h8
    } cps_power_state_type;

endpackage : cps_pkg

// File: design/cps_sync.sv
`timescale 1ns/1ps
module cps_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one_reg;

    // First stage is read by the second stage only
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage_one_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage_one_reg <= async_in;
            sync_out <= stage_one_reg;
        end
    end

endmodule : cps_sync

// File: sim/cps_host_model.sv
`timescale 1ns/1ps
module cps_host_model (
    // Clock
    input wire logic sys_clk,
    // Parallel side of the management bus front end
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // Bus idle from time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end

    // One-byte write as a one-cycle strobe, launched off the sampling edge
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        reg_addr = addr;
        reg_wdata = data;
        reg_write = 1'b1;
        @(negedge sys_clk);
        reg_write = 1'b0;
        reg_wdata = ~data;  // Stale data scrambled so a late sample shows up
        reg_addr = ~addr;
    endtask : write_reg

    // One-byte read; answer taken while the valid pulse stands, bounded wait
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        int waits;
        waits = 0;
        @(negedge sys_clk);
        reg_addr = addr;
        reg_read = 1'b1;
        @(negedge sys_clk);
        reg_read = 1'b0;
        reg_addr = ~addr;
        while (reg_rvalid !== 1'b1 && waits < 4)
        begin
            @(negedge sys_clk);
            waits++;
        end
        ok = (reg_rvalid === 1'b1);
        data = reg_rdata;
    endtask : read_reg
endmodule : cps_host_model

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] A_PROF = cps_pkg::ADDR_LEGACY_PROFILE_STATUS;
    localparam logic [7:0] A_STAT = cps_pkg::ADDR_CONTROL_INPUT_STATUS;
    localparam logic [7:0] A_GEN = cps_pkg::ADDR_GENERAL_CONFIG;
    logic sys_clk, reset_n, reg_write, reg_read, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, gen_cfg;
    logic [3:0] pins;  // Power request, mode b, mode a, emulation allow
    logic strap, removal, attach, fault, fault_clr, sleep_req, dsw_default;
    logic dsw_closed, req_state;
    logic [2:0] accept;
    logic [1:0] lim_default, lim_custom, lim_out, pcode;
    int n_fail = 0;
    int n_checks = 0;
    logic [7:0] cfg_addr [5] = '{cps_pkg::ADDR_GENERAL_CONFIG, cps_pkg::ADDR_EMULATION_CONFIG,
        cps_pkg::ADDR_SWITCH_CONFIG, cps_pkg::ADDR_ATTACH_DETECT_CONFIG, cps_pkg::ADDR_DATA_SWITCH_CONFIG};
    logic [7:0] cfg_rst [5] = '{cps_pkg::RST_GENERAL_CONFIG, cps_pkg::RST_EMULATION_CONFIG,
        cps_pkg::RST_SWITCH_CONFIG, cps_pkg::RST_ATTACH_DETECT_CONFIG, cps_pkg::RST_DATA_SWITCH_CONFIG};

    cps_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    cps_regs dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .port_power_request(pins[3]), .mode_input_b(pins[2]), .mode_input_a(pins[1]),
        .emulation_allow(pins[0]), .polarity_strap(strap), .legacy_profile_accept(accept),
        .removal_detected(removal), .attach_detected(attach), .fault_detected(fault),
        .fault_cleared(fault_clr), .sleep_request(sleep_req), .data_switch_default(dsw_default),
        .default_limit_behaviour(lim_default), .custom_limit_behaviour(lim_custom),
        .data_switch_closed(dsw_closed), .current_limit_behaviour(lim_out),
        .port_power_request_state(req_state), .power_state_code(pcode), .general_config(gen_cfg));

    // 40 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // A read that never answers leaves unknown data, so it cannot match
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
        logic [7:0] data;
        logic ok;
        host.read_reg(addr, data, ok);
        if (ok !== 1'b1)
            data = 8'hxx;
        check(name, data, exp);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    task automatic do_reset(input logic strap_val);
        @(negedge sys_clk);
        reset_n = 1'b0;
        strap = strap_val;
        idle(6);
        reset_n = 1'b1;
        idle(6);
    endtask : do_reset

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    // Whole run is well under a thousand cycles; cut a hang at 6000
    initial
    begin
        #150000;
        n_fail++;
        results();
    end

    initial
    begin
        reset_n = 1'b0;
        pins = 4'h0;
        {strap, removal, attach, fault, fault_clr, sleep_req, dsw_default} = 7'h40;
        accept = 3'h0;
        lim_default = 2'h1;
        lim_custom = 2'h2;
        do_reset(1'b1);
        // Defaults, then read back a written value and restore
        for (int i = 0; i < 5; i++)
        begin
            rd(cfg_addr[i], cfg_rst[i], "config reset");
            host.write_reg(cfg_addr[i], cfg_rst[i] ^ 8'h24);
            rd(cfg_addr[i], cfg_rst[i] ^ 8'h24, "config rw");
            host.write_reg(cfg_addr[i], cfg_rst[i]);
        end
        check("general out", gen_cfg, cps_pkg::RST_GENERAL_CONFIG);
        done("config");
        // Writes to status and unmapped places leave nothing behind
        host.write_reg(A_PROF, 8'hff);
        host.write_reg(A_STAT, 8'hff);
        host.write_reg(8'h30, 8'hff);
        rd(A_PROF, 8'h00, "profile ro");
        rd(A_STAT, 8'h05, "status ro");
        rd(8'h30, cps_pkg::RST_UNMAPPED_READ, "unmapped");
        done("read only");
        // Each pin alone, then its override alone, with synchroniser delay
        for (int j = 0; j < 4; j++)
        begin
            pins = 4'(1 << j);
            idle(4);
            rd(A_STAT, 8'h05 | 8'(8 << j), "pin state");
            pins = 4'h0;
            host.write_reg(cfg_addr[2], 8'h04 | 8'(16 << j));
            idle(2);
            rd(A_STAT, 8'h05 | 8'(8 << j), "override state");
            check("request out", {7'h0, req_state}, {7'h0, j == 3});
            host.write_reg(cfg_addr[2], 8'h04);
        end
        done("pins");
        // Active-low polarity strap: idle pin means request asserted
        do_reset(1'b0);
        rd(A_STAT, 8'h41, "polarity low");
        do_reset(1'b1);
        done("polarity");
        // Detect, active, error, back to detect
        pins[3] = 1'b1;
        attach = 1'b1;
        idle(4);
        rd(A_STAT, 8'h46, "active code");
        attach = 1'b0;
        fault = 1'b1;
        idle(2);
        rd(A_STAT, 8'h47, "error code");
        fault = 1'b0;
        fault_clr = 1'b1;
        idle(2);
        fault_clr = 1'b0;
        rd(A_STAT, 8'h45, "detect code");
        // Sleep keeps general config; an access wakes the device
        pins[3] = 1'b0;
        host.write_reg(A_GEN, 8'h3d);
        sleep_req = 1'b1;
        idle(2);
        sleep_req = 1'b0;
        idle(1);
        check("sleep code", {6'h0, pcode}, {6'h0, cps_pkg::PSTATE_CODE_SLEEP});
        check("general kept", gen_cfg, 8'h3d);
        rd(A_STAT, 8'h05, "wake code");
        rd(A_GEN, 8'h3d, "general read");
        host.write_reg(A_GEN, cps_pkg::RST_GENERAL_CONFIG);
        done("power");
        // Each legacy profile: set, steering, then a different clearing cause
        pins[3] = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            host.write_reg(cfg_addr[4], {7'h0a, i[0]});
            dsw_default = ~i[0];
            idle(3);
            accept = 3'(1 << i);
            idle(1);
            accept = 3'h0;
            idle(2);
            rd(A_PROF, 8'(1 << i), "profile set");
            check("data switch", {7'h0, dsw_closed}, {7'h0, i[0]});
            check("limit", {6'h0, lim_out}, {6'h0, lim_custom});
            case (i)
                0: removal = 1'b1;
                1: pins[3] = 1'b0;
                default: pins[1] = ~pins[1];
            endcase
            idle(4);
            removal = 1'b0;
            pins[3] = 1'b1;
            idle(4);
            rd(A_PROF, 8'h00, "profile clear");
        end
        done("legacy");
        results();
    end
endmodule : tb
